//--- shared/spisr_pkg.sv
// Constants and state type of the serial port status and data register block
package spisr_pkg;

	localparam int ADDR_W = 8;

	// Register indices; byte address is four times the index
	localparam logic [ADDR_W-3:0] IDX_CTRL = 6'h10;
	localparam logic [ADDR_W-3:0] IDX_STAT = 6'h11;
	localparam logic [ADDR_W-3:0] IDX_DATA = 6'h12;

	// Control register fields
	localparam int CTL_RXIE = 7;
	localparam int CTL_MSTR = 5;
	localparam int CTL_EN   = 1;
	localparam int CTL_TXIE = 0;

	// Status and control register fields
	localparam int ST_RXF    = 7;
	localparam int ST_ERROR_IRQ_ENABLE  = 6;
	localparam int ST_OVF    = 5;
	localparam int ST_MODE_FAULT_FLAG   = 4;
	localparam int ST_TXE    = 3;
	localparam int ST_MODE_FAULT_DETECT_ENABLE = 2;
	localparam int ST_RATE   = 0;

	localparam logic [7:0] CTL_RESET  = 8'h20;
	localparam logic [7:0] STAT_RESET = 8'h08;
	localparam logic [2:0] LAST_BIT   = 3'h7;

	// Master baud divisor per rate code
	localparam logic [7:0] BD_00 = 8'h02;
	localparam logic [7:0] BD_01 = 8'h08;
	localparam logic [7:0] BD_10 = 8'h20;
	localparam logic [7:0] BD_11 = 8'h80;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_XFER = 2'b10
	} spisr_mode_t;

	typedef struct packed {
		spisr_mode_t st;
		logic        rx_ie;
		logic        master;
		logic        en;
		logic        tx_ie;
		logic        err_ie;
		logic        mode_fault_detect_enable;
		logic [1:0]  rate;
		logic        rx_full;
		logic        ovf;
		logic        mode_fault_flag;
		logic        tx_empty;
		logic        rx_arm;
		logic        ovf_arm;
		logic        mode_fault_flag_arm;
		logic [7:0]  shift;
		logic        rx_bit;
		logic [2:0]  bit_cnt;
		logic        sclk;
		logic        ss_prev;
		logic        sclk_in_prev;
		logic        sclk_oe;
		logic        mosi_oe;
		logic        miso_oe;
		logic        ss_owned;
		logic        irq;
		logic        pready;
		logic        pslverr;
		logic [7:0]  prdata;
	} spisr_state_t;

endpackage

//--- hdl/spisr_baud_div.sv
// Master baud tick generator: one pulse every divisor cycles
`timescale 1ns/1ns
module spisr_baud_div
(
	input  wire logic       core_clk,
	input  wire logic       reset,
	input  wire logic       run,
	input  wire logic [1:0] rate,
	output logic            tick
);

	logic [7:0] div;
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;

	// Half serial period equals the divisor, so a full period is twice it
	always_comb
	begin
		unique case (rate)
			2'b00: div = spisr_pkg::BD_00;
			2'b01: div = spisr_pkg::BD_01;
			2'b10: div = spisr_pkg::BD_10;
			2'b11: div = spisr_pkg::BD_11;
		endcase
		tick = run && (cnt_reg == 8'h00);
		if (!run || tick)
			cnt_next = div - 8'h01;
		else
			cnt_next = cnt_reg - 8'h01;
	end

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			cnt_reg <= 8'h00;
		else
			cnt_reg <= cnt_next;
	end

endmodule

//--- hdl/spisr_core.sv
// Serial port status, baud select and data registers with byte shifter
//
// Functional notes
// - Completed received byte sets receiver-full flag
// - Receiver-full with enable raises interrupt request
// - Receiver-full clears: status read, then data read
// - Error enable gates overflow and mode-fault interrupts
// - Overflow keeps stored byte, drops new byte
// - Overflow clears: status read, then data read
// - Slave: select rising mid-transfer sets mode fault
// - Master: select low sets mode fault
// - Mode fault clears: status read, control write
// - Transmit hand-off sets transmitter-empty, may interrupt
// - Data write clears transmitter-empty; reset sets it
// - Mode-fault enable permits set, never clears flag
// - Master without detection releases select pin
// - Slave always owns select pin as input
// - Rate code selects divisor 2, 8, 32, 128
// - Serial clock is base clock over twice divisor
// - Separate transmit and receive data, not reset
// - Receive enable gates receiver-full interrupt
// - Transmit enable gates transmitter-empty interrupt
// - Slave only when master bit low, select low
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ns
module spisr_core
(
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        ss_n_in,
	input  wire logic        sclk_in,
	input  wire logic        mosi_in,
	input  wire logic        miso_in,
	output logic             sclk_out,
	output logic             sclk_oe,
	output logic             mosi_out,
	output logic             mosi_oe,
	output logic             miso_out,
	output logic             miso_oe,
	output logic             ss_owned,
	output logic             irq
);

	spisr_pkg::spisr_state_t r;
	spisr_pkg::spisr_state_t n;

	logic [7:0] rx_data_reg;
	logic [7:0] tx_data_reg;
	logic [7:0] rx_byte;
	logic [7:0] rd_mux;
	logic       rx_load;
	logic       tx_wr;
	logic       tick;
	logic       acc;
	logic       xfer;
	logic       is_ctrl;
	logic       is_stat;
	logic       is_data;
	logic       m_mode;
	logic       s_mode;
	logic       rise;
	logic       fall;
	logic       ss_rise;
	logic       ss_fall;

	spisr_baud_div u_baud
	(
		.core_clk (core_clk),
		.reset    (reset),
		.run      (r.st == spisr_pkg::ST_XFER && m_mode),
		.rate     (r.rate),
		.tick     (tick)
	);

	always_comb
	begin
		n       = r;
		rx_load = 1'b0;
		tx_wr   = 1'b0;
		rx_byte = 8'h00;
		rise    = 1'b0;
		fall    = 1'b0;
		rd_mux  = 8'h00;

		acc     = psel && penable;
		// One wait state: the access phase always takes two cycles
		xfer    = acc && r.pready;
		is_ctrl = paddr == {spisr_pkg::IDX_CTRL, 2'b00};
		is_stat = paddr == {spisr_pkg::IDX_STAT, 2'b00};
		is_data = paddr == {spisr_pkg::IDX_DATA, 2'b00};
		m_mode  = r.en && r.master;
		s_mode  = r.en && !r.master;
		ss_rise = !r.ss_prev && ss_n_in;
		ss_fall = r.ss_prev && !ss_n_in;

		if (is_ctrl)
		begin
			rd_mux[spisr_pkg::CTL_RXIE] = r.rx_ie;
			rd_mux[spisr_pkg::CTL_MSTR] = r.master;
			rd_mux[spisr_pkg::CTL_EN]   = r.en;
			rd_mux[spisr_pkg::CTL_TXIE] = r.tx_ie;
		end
		else if (is_stat)
		begin
			rd_mux[spisr_pkg::ST_RXF]    = r.rx_full;
			rd_mux[spisr_pkg::ST_ERROR_IRQ_ENABLE]  = r.err_ie;
			rd_mux[spisr_pkg::ST_OVF]    = r.ovf;
			rd_mux[spisr_pkg::ST_MODE_FAULT_FLAG]   = r.mode_fault_flag;
			rd_mux[spisr_pkg::ST_TXE]    = r.tx_empty;
			rd_mux[spisr_pkg::ST_MODE_FAULT_DETECT_ENABLE] = r.mode_fault_detect_enable;
			rd_mux[spisr_pkg::ST_RATE+:2] = r.rate;
		end
		else if (is_data)
			rd_mux = rx_data_reg;

		n.pready  = acc && !r.pready;
		n.pslverr = acc && !r.pready && !(is_ctrl || is_stat || is_data);
		n.prdata  = (acc && !r.pready && !pwrite) ? rd_mux : 8'h00;

		// Arming uses the value the software actually saw on the bus
		if (xfer && !pwrite && is_stat)
		begin
			n.rx_arm   = r.prdata[spisr_pkg::ST_RXF];
			n.ovf_arm  = r.prdata[spisr_pkg::ST_OVF];
			n.mode_fault_flag_arm = r.prdata[spisr_pkg::ST_MODE_FAULT_FLAG];
		end

		if (xfer && !pwrite && is_data)
		begin
			if (r.rx_arm)
			begin
				n.rx_full = 1'b0;
				n.rx_arm  = 1'b0;
			end
			if (r.ovf_arm)
			begin
				n.ovf     = 1'b0;
				n.ovf_arm = 1'b0;
			end
		end

		if (xfer && pwrite && is_ctrl)
		begin
			n.rx_ie  = pwdata[spisr_pkg::CTL_RXIE];
			n.master = pwdata[spisr_pkg::CTL_MSTR];
			n.en     = pwdata[spisr_pkg::CTL_EN];
			n.tx_ie  = pwdata[spisr_pkg::CTL_TXIE];
			if (r.mode_fault_flag_arm)
			begin
				n.mode_fault_flag     = 1'b0;
				n.mode_fault_flag_arm = 1'b0;
			end
		end

		if (xfer && pwrite && is_stat)
		begin
			n.err_ie = pwdata[spisr_pkg::ST_ERROR_IRQ_ENABLE];
			n.mode_fault_detect_enable = pwdata[spisr_pkg::ST_MODE_FAULT_DETECT_ENABLE];
			n.rate   = pwdata[spisr_pkg::ST_RATE+:2];
		end

		if (xfer && pwrite && is_data)
		begin
			tx_wr      = 1'b1;
			n.tx_empty = 1'b0;
		end

		// Fault detection comes after the bus so a set beats a clear
		if (m_mode && r.mode_fault_detect_enable && !ss_n_in)
			n.mode_fault_flag = 1'b1;
		if (s_mode && r.mode_fault_detect_enable && ss_rise && r.st == spisr_pkg::ST_XFER)
			n.mode_fault_flag = 1'b1;

		unique case (r.st)
			spisr_pkg::ST_IDLE:
			begin
				if ((m_mode && !r.tx_empty && !r.mode_fault_flag) || (s_mode && ss_fall))
				begin
					n.st      = spisr_pkg::ST_XFER;
					n.shift   = tx_data_reg;
					n.bit_cnt = 3'h0;
					n.sclk    = 1'b0;
					if (!r.tx_empty)
						n.tx_empty = 1'b1;
				end
			end
			spisr_pkg::ST_XFER:
			begin
				// A raised select drops the slave out mid-byte
				if (!r.en || (m_mode && r.mode_fault_flag) || (s_mode && ss_n_in))
				begin
					n.st   = spisr_pkg::ST_IDLE;
					n.sclk = 1'b0;
				end
				else
				begin
					if (m_mode)
					begin
						rise = tick && !r.sclk;
						fall = tick && r.sclk;
						if (tick)
							n.sclk = !r.sclk;
					end
					else
					begin
						rise = sclk_in && !r.sclk_in_prev;
						fall = !sclk_in && r.sclk_in_prev;
					end
					if (rise)
						n.rx_bit = m_mode ? miso_in : mosi_in;
					if (fall)
					begin
						n.shift   = {r.shift[6:0], r.rx_bit};
						n.bit_cnt = r.bit_cnt + 3'h1;
						if (r.bit_cnt == spisr_pkg::LAST_BIT)
						begin
							n.st    = spisr_pkg::ST_IDLE;
							rx_byte = {r.shift[6:0], r.rx_bit};
							// A pending data read in this cycle frees the register
							if (n.rx_full)
								n.ovf = 1'b1;
							else
							begin
								rx_load   = 1'b1;
								n.rx_full = 1'b1;
							end
						end
					end
				end
			end
			default:
			begin
				n.st = spisr_pkg::ST_IDLE;
			end
		endcase

		n.ss_prev      = ss_n_in;
		n.sclk_in_prev = sclk_in;
		n.sclk_oe      = n.en && n.master && !n.mode_fault_flag;
		n.mosi_oe      = n.en && n.master && !n.mode_fault_flag;
		n.miso_oe      = n.en && !n.master && !ss_n_in;
		n.ss_owned     = n.en && (!n.master || n.mode_fault_detect_enable);
		n.irq          = (n.rx_full && n.rx_ie)
		               || (n.tx_empty && n.tx_ie)
		               || (n.err_ie && (n.ovf || n.mode_fault_flag));
	end

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			r              <= '0;
			r.st           <= spisr_pkg::ST_IDLE;
			r.master       <= spisr_pkg::CTL_RESET[spisr_pkg::CTL_MSTR];
			r.tx_empty     <= spisr_pkg::STAT_RESET[spisr_pkg::ST_TXE];
			r.ss_prev      <= 1'b1;
		end
		else
			r <= n;
	end

	// Data registers keep their contents through reset
	always_ff @(posedge core_clk)
	begin
		if (rx_load)
			rx_data_reg <= rx_byte;
		if (tx_wr)
			tx_data_reg <= pwdata[7:0];
	end

	assign prdata   = {24'h000000, r.prdata};
	assign pready   = r.pready;
	assign pslverr  = r.pslverr;
	assign sclk_out = r.sclk;
	assign sclk_oe  = r.sclk_oe;
	assign mosi_out = r.shift[7];
	assign mosi_oe  = r.mosi_oe;
	assign miso_out = r.shift[7];
	assign miso_oe  = r.miso_oe;
	assign ss_owned = r.ss_owned;
	assign irq      = r.irq;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	a_rx_full_set: assert property (rx_load |=> r.rx_full)
		else $error("receiver full not set after byte load");

	a_rx_irq_on: assert property (r.rx_full && r.rx_ie |-> r.irq)
		else $error("receiver full interrupt missing");

	a_rx_clear_seq: assert property ($fell(r.rx_full) |->
		$past(xfer && !pwrite && is_data) && $past(r.rx_arm))
		else $error("receiver full cleared without status then data read");

	a_err_gate: assert property (!r.err_ie && !(r.rx_full && r.rx_ie)
		&& !(r.tx_empty && r.tx_ie) |-> !r.irq)
		else $error("error interrupt not gated");

	a_ovf_keep: assert property ($rose(r.ovf) |-> $stable(rx_data_reg))
		else $error("overflow changed stored byte");

	a_mode_fault_flag_master: assert property (m_mode && r.mode_fault_detect_enable && !ss_n_in |=> r.mode_fault_flag)
		else $error("master mode fault not flagged");

	a_mode_fault_flag_slave: assert property (s_mode && r.mode_fault_detect_enable && ss_rise
		&& r.st == spisr_pkg::ST_XFER |=> r.mode_fault_flag)
		else $error("slave mode fault not flagged");

	a_mode_fault_flag_clear: assert property ($fell(r.mode_fault_flag) |->
		$past(xfer && pwrite && is_ctrl) && $past(r.mode_fault_flag_arm))
		else $error("mode fault cleared out of sequence");

	a_tx_empty_wr: assert property (xfer && pwrite && is_data |=> !r.tx_empty)
		else $error("data write left transmitter empty");

	a_tx_handoff: assert property (r.st == spisr_pkg::ST_IDLE && !r.tx_empty
		&& n.st == spisr_pkg::ST_XFER |=> r.tx_empty)
		else $error("hand-off did not set transmitter empty");

	a_mode_fault_detect_enable_keep: assert property (r.mode_fault_flag && !(xfer && pwrite && is_ctrl)
		|=> r.mode_fault_flag)
		else $error("mode fault flag lost");

	a_pready_wait: assert property (acc && !r.pready |=> r.pready)
		else $error("bus answer late");

	c_rx_byte: cover property (rx_load);
	c_overflow: cover property ($rose(r.ovf));
	c_mode_fault: cover property ($rose(r.mode_fault_flag));
	c_tx_handoff: cover property ($rose(r.tx_empty));
	c_slave_byte: cover property (rx_load && s_mode);

endmodule

//--- verification/spisr_slave_model.sv
// Far-side serial slave model answering the block in master mode
`timescale 1ns/1ns
module spisr_slave_model
(
	input  wire logic       sclk,
	input  wire logic       mosi,
	input  wire logic [7:0] reply,
	input  wire logic       load,
	output logic            miso,
	output logic [7:0]      got
);
	logic [7:0] sh;
	initial sh = 8'h00;
	assign miso = sh[7];
	always @(posedge load)
		sh <= reply;
	// Mode 0: sample on rise, next bit on fall
	always @(posedge sclk)
		got <= {got[6:0], mosi};
	// Inverted fill so a stale line never looks like held data
	always @(negedge sclk)
		sh <= {sh[6:0], ~sh[7]};
endmodule

//--- verification/test_spisr_core.sv
// Self-checking bench for the serial port status and data block
`timescale 1ns/1ns
module test_spisr_core;
	typedef struct packed {
		logic       w;
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] q;
		logic       e;
	} spisr_row_t;
	logic        core_clk, reset, psel, penable, pwrite, pready, pslverr, irq;
	logic        ss_n_in, sclk_in, mosi_in, miso_in, sclk_out, sclk_oe, mosi_out, mosi_oe;
	logic        miso_out, miso_oe, ss_owned, ld;
	logic [7:0]  paddr, rep, got;
	logic [31:0] pwdata, prdata;
	int          err_count, cmp_count, cyc;
	time         t_last, t_prev;
	spisr_row_t  rows [0:6];
	// Outputs watched by bit_chk, picked by index so they are read after the wait
	localparam int O_IRQ     = 0;
	localparam int O_OWN     = 1;
	localparam int O_MISO_OE = 2;
	localparam int O_MISO    = 3;
	localparam int O_SCLK_OE = 4;
	localparam int O_MOSI_OE = 5;
	localparam logic [7:0] SL_BYTE = 8'hB4;
	logic [5:0]  obs;
	assign obs = {mosi_oe, sclk_oe, miso_out, miso_oe, ss_owned, irq};

	spisr_core dut (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ss_n_in(ss_n_in), .sclk_in(sclk_in), .mosi_in(mosi_in),
		.miso_in(miso_in), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .mosi_out(mosi_out),
		.mosi_oe(mosi_oe), .miso_out(miso_out), .miso_oe(miso_oe), .ss_owned(ss_owned),
		.irq(irq));
	spisr_slave_model slave_m (.sclk(sclk_out), .mosi(mosi_out), .reply(rep), .load(ld),
		.miso(miso_in), .got(got));

	always #20 core_clk = ~core_clk;
	always @(posedge sclk_out)
	begin
		t_prev = t_last;
		t_last = $time;
	end

	task automatic end_sim;
		$display("errors %0d checks %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Hang guard: the whole run needs well under ten thousand cycles
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			err_count++;
			end_sim();
		end
	end

	task automatic chk(input logic [15:0] g, input logic [15:0] x);
		cmp_count++;
		if (g !== x)
		begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, g, x);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1)
			@(posedge core_clk);
		q = prdata[7:0];
		e = pslverr;
		chk(prdata[31:16] | {8'h00, prdata[15:8]}, 16'h0000);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic       e;
		apb(1'b1, a, d, q, e);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		logic [7:0] q;
		logic       e;
		apb(1'b0, a, 8'h00, q, e);
		chk({8'h00, q}, {8'h00, x});
	endtask

	task automatic bit_chk(input int s, input logic x);
		repeat (3) @(posedge core_clk);
		chk({15'h0000, obs[s]}, {15'h0000, x});
	endtask

	task automatic arm(input logic [7:0] y);
		rep <= y;
		ld <= 1'b1;
		@(posedge core_clk);
		ld <= 1'b0;
	endtask

	task automatic done;
		repeat (8) @(negedge sclk_out);
		repeat (4) @(posedge core_clk);
	endtask

	// Data write only while transmitter empty reads high
	task automatic send(input logic [1:0] r, input logic [7:0] t, input logic [7:0] y);
		arm(y);
		wr(8'h48, t);
		done();
		chk(16'((t_last - t_prev) / 40), 16'h0004 << (2 * r));
		chk({8'h00, got}, {8'h00, t});
	endtask

	initial
	begin
		logic [7:0] q;
		logic       e;
		rows[0] = '{1'b0, 8'h40, 8'h00, 8'h20, 1'b0};
		rows[1] = '{1'b0, 8'h44, 8'h00, 8'h08, 1'b0};
		rows[2] = '{1'b1, 8'h44, 8'h47, 8'h00, 1'b0};
		rows[3] = '{1'b0, 8'h44, 8'h00, 8'h4F, 1'b0};
		rows[4] = '{1'b1, 8'h44, 8'h00, 8'h00, 1'b0};
		rows[5] = '{1'b1, 8'h4C, 8'h5A, 8'h00, 1'b1};
		rows[6] = '{1'b0, 8'h4C, 8'h00, 8'h00, 1'b1};
		core_clk = 1'b0;
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		ss_n_in = 1'b1;
		sclk_in = 1'b0;
		mosi_in = 1'b0;
		rep = 8'h00;
		ld = 1'b0;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		chk({15'h0000, irq}, 16'h0000);
		for (int i = 0; i < 7; i++)
		begin
			apb(rows[i].w, rows[i].a, rows[i].d, q, e);
			chk({8'h00, q}, {8'h00, rows[i].q});
			chk({15'h0000, e}, {15'h0000, rows[i].e});
		end
		wr(8'h40, 8'h22);
		bit_chk(O_OWN, 1'b0);
		bit_chk(O_SCLK_OE, 1'b1);
		bit_chk(O_MOSI_OE, 1'b1);
		for (int r = 0; r < 4; r++)
		begin
			wr(8'h44, 8'(r));
			send(2'(r), 8'hA5 ^ 8'(r), 8'h3C + 8'(r));
			rd(8'h44, 8'h88 | 8'(r));
			rd(8'h48, 8'h3C + 8'(r));
			rd(8'h44, 8'h08 | 8'(r));
		end
		wr(8'h44, 8'h40);
		send(2'h0, 8'h11, 8'hC3);
		send(2'h0, 8'h22, 8'h5E);
		rd(8'h48, 8'hC3);
		bit_chk(O_IRQ, 1'b1);
		rd(8'h44, 8'hE8);
		rd(8'h48, 8'hC3);
		rd(8'h44, 8'h48);
		bit_chk(O_IRQ, 1'b0);
		wr(8'h44, 8'h00);
		wr(8'h40, 8'h21);
		bit_chk(O_IRQ, 1'b1);
		arm(8'h69);
		wr(8'h48, 8'h96);
		bit_chk(O_IRQ, 1'b0);
		wr(8'h40, 8'h23);
		bit_chk(O_IRQ, 1'b1);
		done();
		wr(8'h40, 8'hA2);
		bit_chk(O_IRQ, 1'b1);
		wr(8'h40, 8'h22);
		bit_chk(O_IRQ, 1'b0);
		rd(8'h44, 8'h88);
		rd(8'h48, 8'h69);
		wr(8'h44, 8'h04);
		ss_n_in <= 1'b0;
		bit_chk(O_OWN, 1'b1);
		bit_chk(O_SCLK_OE, 1'b0);
		bit_chk(O_MOSI_OE, 1'b0);
		ss_n_in <= 1'b1;
		rd(8'h44, 8'h1C);
		wr(8'h44, 8'h00);
		rd(8'h44, 8'h18);
		wr(8'h40, 8'h22);
		rd(8'h44, 8'h08);
		bit_chk(O_OWN, 1'b0);
		wr(8'h40, 8'h02);
		wr(8'h44, 8'h04);
		ss_n_in <= 1'b0;
		bit_chk(O_MISO_OE, 1'b1);
		bit_chk(O_MISO, 1'b1);
		bit_chk(O_OWN, 1'b1);
		repeat (3)
		begin
			repeat (4) @(posedge core_clk);
			sclk_in <= ~sclk_in;
		end
		ss_n_in <= 1'b1;
		bit_chk(O_MISO_OE, 1'b0);
		rd(8'h44, 8'h1C);
		sclk_in <= 1'b0;
		wr(8'h40, 8'h02);
		// Full slave byte, MSB first, clocked by the bench
		ss_n_in <= 1'b0;
		for (int b = 7; b >= 0; b--)
		begin
			mosi_in <= SL_BYTE[b];
			repeat (4) @(posedge core_clk);
			sclk_in <= 1'b1;
			repeat (4) @(posedge core_clk);
			sclk_in <= 1'b0;
		end
		repeat (4) @(posedge core_clk);
		ss_n_in <= 1'b1;
		rd(8'h44, 8'h8C);
		// Mid-run reset: flags return to reset values, data registers keep theirs
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		rd(8'h40, 8'h20);
		rd(8'h44, 8'h08);
		rd(8'h48, SL_BYTE);
		end_sim();
	end
endmodule
